// ---- design/adcsc_ctrl.v ----
// Purpose: Status and control logic of a successive approximation converter.
// Assumes: Single clock sys_clk at 200 MHz, synchronous active-low reset,
//          hardware trigger and comparator inputs synchronous to sys_clk.
// Notes:   Register port answers reads one cycle later; unmapped reads 0.
//
// Behaviour
// - With compare disabled the done flag in bit 7 sets on every finished conversion.
// - With compare enabled the done flag sets at conversion end only if the compare holds.
// - A write of the status/control register or read of the result low byte clears done unless a conversion completes in that cycle.
// - The done interrupt asserts when done sets while the enable in bit 6 and interrupt mask bit 0 are both high.
// - With continuous off, one conversion follows each write in software trigger mode or each hardware trigger in hardware mode.
// - With continuous on, a write in software trigger mode or a trigger in hardware mode starts back-to-back conversions.
// - Bits 4:0 choose the input; code n selects channel n for n from 0 to 22.
// - The all-ones channel code powers the converter off and isolates the input.
// - Stopping continuous mode with the all-ones code runs no further conversion.
// - With continuous off the converter drops to low power after each conversion.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`include "adcsc_map.vh"

module adcsc_ctrl #(
  parameter RES_W = 10,
  parameter NUM_CH = 23,
  parameter STEP_CYCLES = `ADCSC_CONV_CYCLES / 10
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [`ADCSC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire hardware_conv_trigger,
  input wire cmp_hi,
  output reg [RES_W-1:0] dac_code,
  output reg [NUM_CH-1:0] input_connect,
  output reg converter_power_on,
  output reg done_irq
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg conversion_done_flag_r;
  reg done_irq_enable_r;
  reg continuous_conv_enable_r;
  reg [4:0] input_channel_select_r;
  reg hw_trig_sel_r;
  reg compare_function_enable_r;
  reg compare_greater_r;
  reg [RES_W-1:0] cmp_value_r;
  reg [RES_W-1:0] result_r;
  reg [1:0] irq_status_r;
  reg [1:0] irq_mask_r;
  reg trig_prev_r;
  reg pending_r;

  wire sar_busy;
  wire sar_done;
  wire [RES_W-1:0] sar_result;
  wire [RES_W-1:0] sar_dac;

  wire wr_sc = reg_wr && (reg_addr == `ADCSC_REG_SC);
  wire rd_lo = reg_rd && (reg_addr == `ADCSC_REG_RES_LO);
  wire ch_off = (input_channel_select_r == `ADCSC_CH_OFF);
  wire new_ch_off = (reg_wdata[`ADCSC_CH_HI:`ADCSC_CH_LO] == `ADCSC_CH_OFF);
  wire trig_edge = hardware_conv_trigger && !trig_prev_r;

  // Compare outcome against the stored threshold
  wire cmp_true = compare_greater_r ? (sar_result >= cmp_value_r)
                                    : (sar_result < cmp_value_r);
  // Done qualified by compare function
  wire done_event = sar_done &&
    (!compare_function_enable_r || cmp_true);

  // Start request: a register write in software mode, a trigger edge in
  // hardware mode; a write that selects the off code starts nothing.
  wire start_req = hw_trig_sel_r ? trig_edge
                                 : (wr_sc && !new_ch_off);

  // Sequencer start pulse from the state machine
  reg sar_start;

  // Next-state logic for the conversion sequencer
  always @* begin
    state_nxt = state_r;
    sar_start = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pending_r && !ch_off) begin
          state_nxt = ST_CONV;
          sar_start = 1'b1;
        end
      end
      ST_CONV: begin
        if (ch_off) begin
          state_nxt = ST_IDLE;
        end else if (sar_done) begin
          state_nxt = continuous_conv_enable_r ? ST_WAIT : ST_IDLE;
        end
      end
      ST_WAIT: begin
        // One idle cycle lets the sequencer clear busy before restarting
        if (ch_off || !continuous_conv_enable_r) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = ST_CONV;
          sar_start = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  adcsc_sar #(
    .RES_W(RES_W),
    .STEP_CYCLES(STEP_CYCLES)
  ) u_sar (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(sar_start),
    .abort(ch_off),
    .cmp_hi(cmp_hi),
    .dac_code(sar_dac),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result)
  );

  // Control registers and sequencer state
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      done_irq_enable_r <= 1'b0;
      continuous_conv_enable_r <= 1'b0;
      input_channel_select_r <= `ADCSC_CH_OFF;
      hw_trig_sel_r <= 1'b0;
      compare_function_enable_r <= 1'b0;
      compare_greater_r <= 1'b0;
      cmp_value_r <= {RES_W{1'b0}};
      trig_prev_r <= 1'b0;
      pending_r <= 1'b0;
      result_r <= {RES_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      trig_prev_r <= hardware_conv_trigger;
      if (wr_sc) begin
        done_irq_enable_r <= reg_wdata[`ADCSC_IEN_BIT];
        continuous_conv_enable_r <= reg_wdata[`ADCSC_CONT_BIT];
        input_channel_select_r <= reg_wdata[`ADCSC_CH_HI:`ADCSC_CH_LO];
      end
      if (reg_wr && reg_addr == `ADCSC_REG_CFG) begin
        hw_trig_sel_r <= reg_wdata[`ADCSC_CFG_HWTRG_BIT];
        compare_function_enable_r <= reg_wdata[`ADCSC_CFG_CMPEN_BIT];
        compare_greater_r <= reg_wdata[`ADCSC_CFG_CMPGT_BIT];
      end
      if (reg_wr && reg_addr == `ADCSC_REG_CMP) begin
        cmp_value_r <= {{(RES_W-8){1'b0}}, reg_wdata};
      end
      // A pending start is consumed when the sequencer launches
      if (start_req) begin
        pending_r <= 1'b1;
      end else if (sar_start || ch_off) begin
        pending_r <= 1'b0;
      end
      if (sar_done) begin
        result_r <= sar_result;
      end
    end
  end

  // Done flag: a completion in the same cycle as a clear wins, so no
  // conversion is lost to a racing write or result read
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      conversion_done_flag_r <= 1'b0;
    end else if (done_event) begin
      conversion_done_flag_r <= 1'b1;
    end else if (wr_sc || rd_lo) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  // Sticky interrupt status; bit 1 records a done that found the flag set
  wire [1:0] irq_set;
  assign irq_set[`ADCSC_IRQ_DONE_BIT] = done_event && done_irq_enable_r;
  assign irq_set[`ADCSC_IRQ_OVR_BIT] = done_event && conversion_done_flag_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_irq
      // Set beats a write-one-to-clear in the same cycle
      always @(posedge sys_clk) begin
        if (!reset_n) begin
          irq_status_r[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_status_r[gi] <= 1'b1;
        end else if (reg_wr && reg_addr == `ADCSC_REG_IRQ_ST &&
                     reg_wdata[gi]) begin
          irq_status_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mask register, then one level output from a flop
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_mask_r <= `ADCSC_IRQ_RST;
      done_irq <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `ADCSC_REG_IRQ_MSK) begin
        irq_mask_r <= reg_wdata[1:0];
      end
      // Clearing the enable also drops a pending done interrupt
      done_irq <= |(irq_status_r & irq_mask_r &
                    {1'b1, done_irq_enable_r});
    end
  end

  // Analog-side outputs: power, input switch and DAC code
  genvar ci;
  generate
    for (ci = 0; ci < NUM_CH; ci = ci + 1) begin : g_mux
      localparam [4:0] CH_CODE = ci;
      // Reserved and off codes close no switch
      always @(posedge sys_clk) begin
        if (!reset_n) begin
          input_connect[ci] <= 1'b0;
        end else begin
          input_connect[ci] <= !ch_off &&
            (input_channel_select_r == CH_CODE);
        end
      end
    end
  endgenerate

  // Power stays up only while converting; idle means low power
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      converter_power_on <= 1'b0;
      dac_code <= {RES_W{1'b0}};
    end else begin
      converter_power_on <= !ch_off && (sar_busy || sar_start ||
        state_r == ST_WAIT);
      dac_code <= sar_dac;
    end
  end

  // Read mux, data valid in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADCSC_REG_SC: reg_rdata <= {conversion_done_flag_r,
          done_irq_enable_r, continuous_conv_enable_r,
          input_channel_select_r};
        `ADCSC_REG_RES_LO: reg_rdata <= result_r[7:0];
        `ADCSC_REG_RES_HI: reg_rdata <= {{(16-RES_W){1'b0}},
          result_r[RES_W-1:8]};
        `ADCSC_REG_CFG: reg_rdata <= {5'h00, compare_greater_r,
          compare_function_enable_r, hw_trig_sel_r};
        `ADCSC_REG_IRQ_ST: reg_rdata <= {6'h00, irq_status_r};
        `ADCSC_REG_IRQ_MSK: reg_rdata <= {6'h00, irq_mask_r};
        `ADCSC_REG_CMP: reg_rdata <= cmp_value_r[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // adcsc_ctrl

// ---- inc/adcsc_map.vh ----
// Purpose: Register map, field positions and timing counts of the converter
//          status and control block.
// Assumes: Plain register port, one byte-wide register file.
// Notes:   Offsets of registers other than the status/control one are local.
`ifndef ADCSC_MAP_VH
`define ADCSC_MAP_VH

// Register indices on the plain register port
`define ADCSC_ADDR_W 3
`define ADCSC_REG_SC 3'h0
`define ADCSC_REG_RES_LO 3'h1
`define ADCSC_REG_RES_HI 3'h2
`define ADCSC_REG_CFG 3'h3
`define ADCSC_REG_IRQ_ST 3'h4
`define ADCSC_REG_IRQ_MSK 3'h5
`define ADCSC_REG_CMP 3'h6

// Status/control field positions
`define ADCSC_DONE_BIT 7
`define ADCSC_IEN_BIT 6
`define ADCSC_CONT_BIT 5
`define ADCSC_CH_HI 4
`define ADCSC_CH_LO 0

// Configuration register field positions
`define ADCSC_CFG_HWTRG_BIT 0
`define ADCSC_CFG_CMPEN_BIT 1
`define ADCSC_CFG_CMPGT_BIT 2

// Interrupt status bits
`define ADCSC_IRQ_DONE_BIT 0
`define ADCSC_IRQ_OVR_BIT 1

// Reset values
`define ADCSC_SC_RST 8'h1f
`define ADCSC_CFG_RST 3'h0
`define ADCSC_IRQ_RST 2'h0
`define ADCSC_CMP_RST 10'h000

// Channel codes
`define ADCSC_CH_OFF 5'h1f
`define ADCSC_CH_LAST 5'h16

// Conversion time: figure in ns and derived cycle count at 200 MHz
`define ADCSC_CLK_PERIOD_NS 5
`define ADCSC_CONV_TIME_NS 115
`define ADCSC_CONV_CYCLES (`ADCSC_CONV_TIME_NS / `ADCSC_CLK_PERIOD_NS)

`endif

// ---- design/adcsc_sar.v ----
// Purpose: Successive approximation sequencer for the converter core.
// Assumes: Comparator input cmp_hi is synchronous to sys_clk.
// Notes:   One bit is resolved per step; start is ignored while busy.
`include "adcsc_map.vh"

module adcsc_sar #(
  parameter RES_W = 10,
  parameter STEP_CYCLES = 2
) (
  input wire sys_clk,
  input wire reset_n,
  input wire start,
  input wire abort,
  input wire cmp_hi,
  output reg [RES_W-1:0] dac_code,
  output reg busy,
  output reg done,
  output reg [RES_W-1:0] result
);

  reg [RES_W-1:0] trial_r;
  reg [7:0] step_cnt_r;
  reg [RES_W-1:0] bit_r;

  // Last value of the step counter, sized to the counter
  localparam [7:0] STEP_LAST = STEP_CYCLES - 1;

  // Binary search from the MSB down, one bit per step
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      dac_code <= {RES_W{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
      result <= {RES_W{1'b0}};
      trial_r <= {RES_W{1'b0}};
      step_cnt_r <= 8'h00;
      bit_r <= {RES_W{1'b0}};
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (!busy && start) begin
        busy <= 1'b1;
        bit_r <= {1'b1, {(RES_W-1){1'b0}}};
        trial_r <= {1'b1, {(RES_W-1){1'b0}}};
        dac_code <= {1'b1, {(RES_W-1){1'b0}}};
        step_cnt_r <= 8'h00;
      end else if (busy) begin
        if (step_cnt_r == STEP_LAST) begin
          step_cnt_r <= 8'h00;
          // Keep the trial bit when the input is above the DAC level
          if (bit_r == {{(RES_W-1){1'b0}}, 1'b1}) begin
            busy <= 1'b0;
            done <= 1'b1;
            result <= cmp_hi ? trial_r : (trial_r & ~bit_r);
          end else begin
            trial_r <= (cmp_hi ? trial_r : (trial_r & ~bit_r))
                       | (bit_r >> 1);
            dac_code <= (cmp_hi ? trial_r : (trial_r & ~bit_r))
                        | (bit_r >> 1);
            bit_r <= bit_r >> 1;
          end
        end else begin
          step_cnt_r <= step_cnt_r + 8'h01;
        end
      end
    end
  end

endmodule // adcsc_sar

// ---- dv/adcsc_ctrl_props.sv ----
// Purpose: Port-level checks of the converter status/control block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Shadows channel and continuous bits from control writes.
`include "adcsc_map.vh"
module adcsc_ctrl_props #(
  parameter RES_W = 10,
  parameter NUM_CH = 23,
  parameter STEP_CYCLES = 2
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [`ADCSC_ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire hardware_conv_trigger,
  input wire cmp_hi,
  input wire [RES_W-1:0] dac_code,
  input wire [NUM_CH-1:0] input_connect,
  input wire converter_power_on,
  input wire done_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] ch_r;
  logic cont_r;
  // Shadow copy, so checks need no access to the hidden register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ch_r <= `ADCSC_CH_OFF;
      cont_r <= 1'b0;
    end else if (reg_wr && reg_addr == `ADCSC_REG_SC) begin
      ch_r <= reg_wdata[4:0];
      cont_r <= reg_wdata[5];
    end
  end
  sequence seq_sc_write;
    reg_wr && reg_addr == `ADCSC_REG_SC && !converter_power_on;
  endsequence
  sequence seq_sc_read;
    reg_rd && reg_addr == `ADCSC_REG_SC;
  endsequence
  sequence seq_res_read;
    reg_rd && reg_addr == `ADCSC_REG_RES_LO && !converter_power_on;
  endsequence
  a_rdata_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_conn_onehot:
    assert property ($onehot0(input_connect))
    else $error("more than one input connected");
  a_ch_route:
    assert property ($stable(ch_r) |-> input_connect == (ch_r < NUM_CH ?
      {{(NUM_CH-1){1'b0}}, 1'b1} << ch_r : {NUM_CH{1'b0}}))
    else $error("input switch does not follow channel code");
  a_off_power:
    assert property (reg_wr && reg_addr == `ADCSC_REG_SC &&
      reg_wdata[4:0] == 5'h1f |=> ##1 !converter_power_on [*3])
    else $error("converter powered with channel off");
  a_sc_wr_clear:
    assert property (seq_sc_write ##2 seq_sc_read |=> !reg_rdata[7])
    else $error("done flag survived control write");
  a_res_rd_clear:
    assert property (seq_res_read ##2 seq_sc_read |=> !reg_rdata[7])
    else $error("done flag survived result read");
  a_single_rest:
    assert property ($fell(converter_power_on) && !cont_r
      |=> !converter_power_on [*2])
    else $error("single mode did not rest after conversion");
  a_cont_restart:
    assert property ($fell(converter_power_on) && cont_r &&
      ch_r != 5'h1f |-> ##[1:4] converter_power_on)
    else $error("continuous mode did not restart");
endmodule // adcsc_ctrl_props

bind adcsc_ctrl adcsc_ctrl_props #(.RES_W(RES_W), .NUM_CH(NUM_CH),
  .STEP_CYCLES(STEP_CYCLES)) u_props (.sys_clk(sys_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .hardware_conv_trigger(hardware_conv_trigger), .cmp_hi(cmp_hi),
  .dac_code(dac_code), .input_connect(input_connect),
  .converter_power_on(converter_power_on), .done_irq(done_irq));

// ---- dv/tb_top.sv ----
// Purpose: Register-level tests of the converter status/control block.
// Assumes: Comparator held high, so every result is all ones.
// Notes: Short step count keeps each conversion near a dozen cycles.
`include "adcsc_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic trig = 1'b0;
  logic cmp_hi = 1'b1;
  wire [7:0] reg_rdata;
  wire [22:0] conn;
  wire [9:0] dac;
  wire pwr;
  wire irq;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  adcsc_ctrl #(.STEP_CYCLES(1)) dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hardware_conv_trigger(trig), .cmp_hi(cmp_hi), .dac_code(dac),
    .input_connect(conn), .converter_power_on(pwr), .done_irq(irq));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the fewer than a thousand cycles the tests need
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk({24'h0, reg_rdata}, {24'h0, e});
  endtask
  // Counts power-up pulses, so extra or missing conversions both show
  task automatic count_conv(output int c);
    logic prev;
    c = 0;
    prev = 1'b0;
    repeat (60) begin
      @(posedge sys_clk);
      #1 if (pwr === 1'b1 && !prev) c++;
      prev = pwr;
    end
    chk({31'h0, pwr}, 32'h0);
  endtask
  task automatic pulse();
    @(posedge sys_clk);
    trig <= 1'b1;
    @(posedge sys_clk);
    trig <= 1'b0;
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`ADCSC_REG_SC, `ADCSC_SC_RST);
    chk({9'h0, conn}, 32'h0);
    wr(3'h7, 8'h55);
    rd(3'h7, 8'h00);
    wr(`ADCSC_REG_IRQ_MSK, 8'h01);
    wr(`ADCSC_REG_SC, 8'h45);
    count_conv(n);
    chk(n, 1);
    chk({9'h0, conn}, 32'h20);
    chk({22'h0, dac}, 32'h3ff);
    chk({31'h0, irq}, 32'h1);
    rd(`ADCSC_REG_SC, 8'hc5);
    rd(`ADCSC_REG_RES_HI, 8'h03);
    rd(`ADCSC_REG_RES_LO, 8'hff);
    rd(`ADCSC_REG_SC, 8'h45);
    wr(`ADCSC_REG_IRQ_ST, 8'h03);
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, irq}, 32'h0);
    wr(`ADCSC_REG_SC, 8'h16);
    count_conv(n);
    chk({9'h0, conn}, 32'h400000);
    chk({31'h0, irq}, 32'h0);
    rd(`ADCSC_REG_SC, 8'h96);
    wr(`ADCSC_REG_SC, 8'h1f);
    rd(`ADCSC_REG_SC, 8'h1f);
    chk({9'h0, conn}, 32'h0);
    wr(`ADCSC_REG_CMP, 8'h00);
    wr(`ADCSC_REG_CFG, 8'h02);
    wr(`ADCSC_REG_SC, 8'h01);
    count_conv(n);
    rd(`ADCSC_REG_SC, 8'h01);
    wr(`ADCSC_REG_CFG, 8'h06);
    wr(`ADCSC_REG_SC, 8'h01);
    count_conv(n);
    rd(`ADCSC_REG_SC, 8'h81);
    wr(`ADCSC_REG_CFG, 8'h01);
    wr(`ADCSC_REG_SC, 8'h02);
    count_conv(n);
    chk(n, 0);
    pulse();
    count_conv(n);
    chk(n, 1);
    rd(`ADCSC_REG_SC, 8'h82);
    wr(`ADCSC_REG_SC, 8'h23);
    pulse();
    count_conv(n);
    chk(n >= 3, 1);
    wr(`ADCSC_REG_SC, 8'h3f);
    count_conv(n);
    chk(n, 0);
    wr(`ADCSC_REG_CFG, 8'h00);
    wr(`ADCSC_REG_SC, 8'h24);
    count_conv(n);
    chk(n >= 3, 1);
    wr(`ADCSC_REG_SC, 8'h3f);
    count_conv(n);
    chk(n, 0);
    rd(`ADCSC_REG_SC, 8'h3f);
    summarize();
  end
endmodule // tb_top
